// ==== hw/cawd_timebase.sv ====
// Counter array timebase tick generator
`timescale 1ns/1ps
module cawd_timebase
  import cawd_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] tbSel,
  input wire logic timer0Ovf,
  input wire logic eciPin,
  input wire logic extClkPin,
  output logic tick
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic eciS1_q, eciS2_q, eciS3_q;
  logic extS1_q, extS2_q, extS3_q;
  logic [3:0] pre12_q, pre4_q, ext8_q;
  logic eciFall, extRise;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      eciS1_q <= 1'b1;
      eciS2_q <= 1'b1;
      eciS3_q <= 1'b1;
      extS1_q <= 1'b0;
      extS2_q <= 1'b0;
      extS3_q <= 1'b0;
    end
    else
    begin
      eciS1_q <= eciPin;
      eciS2_q <= eciS1_q;
      eciS3_q <= eciS2_q;
      extS1_q <= extClkPin;
      extS2_q <= extS1_q;
      extS3_q <= extS2_q;
    end
  end

  assign eciFall = eciS3_q & ~eciS2_q;
  assign extRise = extS2_q & ~extS3_q;

  // ****************************************
  // Prescalers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pre12_q <= 4'h0;
      pre4_q <= 4'h0;
      ext8_q <= 4'h0;
    end
    else
    begin
      pre12_q <= (pre12_q == CAWD_DIV12 - 4'h1) ? 4'h0 : pre12_q + 4'h1;
      pre4_q <= (pre4_q == CAWD_DIV4 - 4'h1) ? 4'h0 : pre4_q + 4'h1;
      if (extRise)
        ext8_q <= (ext8_q == CAWD_DIV8 - 4'h1) ? 4'h0 : ext8_q + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      tick <= 1'b0;
    else
    begin
      unique case (cawd_tb_e'(tbSel))
        CAWD_TB_SYS12: tick <= (pre12_q == CAWD_DIV12 - 4'h1);
        CAWD_TB_SYS4: tick <= (pre4_q == CAWD_DIV4 - 4'h1);
        CAWD_TB_TMR0: tick <= timer0Ovf;
        CAWD_TB_ECI: tick <= eciFall;
        CAWD_TB_SYS: tick <= 1'b1;
        CAWD_TB_EXT8: tick <= extRise && (ext8_q == CAWD_DIV8 - 4'h1);
        CAWD_TB_RSV6, CAWD_TB_RSV7: tick <= 1'b0;
      endcase
    end
  end

endmodule : cawd_timebase

// ==== hw/cawd_top.sv ====
// Counter array with three compare modules and watchdog on module 2
//
// Behaviour
// - 16-bit PWM: zero full duty, compare-off zero
// - Watchdog compares module 2 high, low is offset
// - Every reset leaves watchdog enabled
// - Watchdog keeps counter running ignoring run bit
// - Watchdog blocks counter byte writes
// - Watchdog write-protects the mode register except enable clear and lock set
// - Watchdog forces module 2 software timer
// - Run bit reads software value only
// - Low overflow at high match resets system
// - Compare high write reloads counter high plus offset
// - Writing module 2 flag forces reset
// - Enable or lock enables; lock holds till reset
// - Clearing enable unlocked disables watchdog
// - Timeout is 256 times offset plus remainder
// - Reset timebase div 12, counter and offset zero
// - Counter wrap sets sticky overflow flag
// - Module match or capture sets sticky flag
// - Unwatched, run bit starts and stops counter
// - Idle suspend bit halts array while idle
// - Three-bit timebase select with reserved codes
// - Mode bit 4 reads zero
// - Match interrupt enable gates module flag request
`timescale 1ns/1ps
module cawd_top
  import cawd_pkg::*;
#(
  parameter int NUM_MODULES = 3
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  input wire logic cpuIdle,
  input wire logic timer0Ovf,
  input wire logic eciPin,
  input wire logic extClkPin,
  input wire logic [NUM_MODULES-1:0] cexIn,
  output logic [NUM_MODULES-1:0] cexOut,
  output logic irqReq,
  output logic wdResetReq
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0] mode_q;
  logic run_q;
  logic ovfFlag_q;
  logic [NUM_MODULES-1:0] matchFlag_q;
  logic [15:0] cnt_q;
  logic [7:0] cmpLo_q [NUM_MODULES];
  logic [7:0] cmpHi_q [NUM_MODULES];
  logic [7:0] mmode_q [NUM_MODULES];
  logic [7:0] effMode [NUM_MODULES];
  logic [NUM_MODULES-1:0] toggle_q;
  logic [NUM_MODULES-1:0] cexS1_q, cexS2_q, cexS3_q;
  logic [NUM_MODULES-1:0] modEvt;
  logic [NUM_MODULES-1:0] modIrq;
  logic [7:0] lowAddr [NUM_MODULES];
  logic [7:0] highAddr [NUM_MODULES];

  logic wdOn, tick, countEn, lowOvf, fullOvf, wdMatch;
  logic wrCtrl, wrMode, wrCntLo, wrCntHi;

  assign lowAddr = '{CAWD_ADDR_CMPLO0, CAWD_ADDR_CMPLO1, CAWD_ADDR_CMPLO2};
  assign highAddr = '{CAWD_ADDR_CMPHI0, CAWD_ADDR_CMPHI1, CAWD_ADDR_CMPHI2};

  assign wrCtrl = sfrWrEn && (sfrAddr == CAWD_ADDR_CTRL);
  assign wrMode = sfrWrEn && (sfrAddr == CAWD_ADDR_MODE);
  assign wrCntLo = sfrWrEn && (sfrAddr == CAWD_ADDR_CNTLO);
  assign wrCntHi = sfrWrEn && (sfrAddr == CAWD_ADDR_CNTHI);

  // Lock alone also enables the watchdog
  assign wdOn = mode_q[CAWD_MODE_WDEN] | mode_q[CAWD_MODE_WATCHDOG_LOCK_BIT];

  // ****************************************
  // Timebase and counter
  // ****************************************
  cawd_timebase u_timebase (
    .clk(clk),
    .srst(srst),
    .tbSel(mode_q[CAWD_MODE_TBMSB:CAWD_MODE_TBLSB]),
    .timer0Ovf(timer0Ovf),
    .eciPin(eciPin),
    .extClkPin(extClkPin),
    .tick(tick)
  );

  // Watchdog forces counting; idle suspend overrides both
  assign countEn = tick && (wdOn || run_q)
    && !(mode_q[CAWD_MODE_IDLE] && cpuIdle);
  assign lowOvf = countEn && (cnt_q[7:0] == CAWD_LOW_MAX);
  assign fullOvf = countEn && (cnt_q == CAWD_CNT_MAX);

  always_ff @(posedge clk)
  begin
    if (srst)
      cnt_q <= CAWD_CNT_RST;
    else if (wrCntLo && !wdOn)
      cnt_q[7:0] <= sfrWrData;
    else if (wrCntHi && !wdOn)
      cnt_q[15:8] <= sfrWrData;
    else if (countEn)
      cnt_q <= cnt_q + 16'h0001;
  end

  // ****************************************
  // Mode register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
      mode_q <= CAWD_MODE_RST;
    else if (wrMode)
    begin
      if (!wdOn)
      begin
        mode_q <= sfrWrData;
        mode_q[CAWD_MODE_UNUSED] <= 1'b0;
      end
      else
      begin
        // Only the enable and lock may move while watched
        if (!mode_q[CAWD_MODE_WATCHDOG_LOCK_BIT] && !sfrWrData[CAWD_MODE_WDEN])
          mode_q[CAWD_MODE_WDEN] <= 1'b0;
        if (sfrWrData[CAWD_MODE_WATCHDOG_LOCK_BIT])
          mode_q[CAWD_MODE_WATCHDOG_LOCK_BIT] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
      run_q <= 1'b0;
    else if (wrCtrl)
      run_q <= sfrWrData[CAWD_CTRL_RUN];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ovfFlag_q <= 1'b0;
    else if (fullOvf)
      ovfFlag_q <= 1'b1;
    else if (wrCtrl)
      ovfFlag_q <= sfrWrData[CAWD_CTRL_OVF];
  end

  // ****************************************
  // Compare modules
  // ****************************************
  generate
    for (genvar n = 0; n < NUM_MODULES; n++)
    begin : g_mod
      localparam bit IS_WD = (n == CAWD_WD_MODULE);
      logic guarded;
      logic hit;
      logic capEvt;
      logic wrLo, wrHi, wrMm;

      assign guarded = IS_WD && wdOn;
      assign effMode[n] = guarded ? CAWD_MMODE_SWTIMER : mmode_q[n];
      assign wrLo = sfrWrEn && (sfrAddr == lowAddr[n]);
      assign wrHi = sfrWrEn && (sfrAddr == highAddr[n]);
      assign wrMm = sfrWrEn && (sfrAddr == CAWD_ADDR_MMODE0 + 8'(n));
      assign hit = countEn && effMode[n][CAWD_MM_ECOM] && (cnt_q == {cmpHi_q[n], cmpLo_q[n]});
      assign capEvt = (effMode[n][CAWD_MM_CAPP] && cexS2_q[n] && !cexS3_q[n])
        || (effMode[n][CAWD_MM_CAPN] && !cexS2_q[n] && cexS3_q[n]);
      assign modEvt[n] = (hit && effMode[n][CAWD_MM_MAT]) || capEvt;
      assign modIrq[n] = matchFlag_q[n] && effMode[n][CAWD_MM_IRQEN];

      always_ff @(posedge clk)
      begin
        if (srst)
          mmode_q[n] <= CAWD_MMODE_RST;
        else if (wrMm && !guarded)
          mmode_q[n] <= sfrWrData;
        else if (wrLo && !guarded)
          mmode_q[n][CAWD_MM_ECOM] <= 1'b0;
        else if (wrHi && !guarded)
          mmode_q[n][CAWD_MM_ECOM] <= 1'b1;
      end

      always_ff @(posedge clk)
      begin
        if (srst)
          cmpLo_q[n] <= CAWD_CMP_RST;
        else if (wrLo)
          cmpLo_q[n] <= sfrWrData;
        else if (capEvt)
          cmpLo_q[n] <= cnt_q[7:0];
        else if (lowOvf && effMode[n][CAWD_MM_PWM] && !effMode[n][CAWD_MM_PWM16])
          cmpLo_q[n] <= cmpHi_q[n];
      end

      always_ff @(posedge clk)
      begin
        if (srst)
          cmpHi_q[n] <= CAWD_CMP_RST;
        else if (wrHi && guarded)
          cmpHi_q[n] <= cnt_q[15:8] + cmpLo_q[n];
        else if (wrHi)
          cmpHi_q[n] <= sfrWrData;
        else if (capEvt)
          cmpHi_q[n] <= cnt_q[15:8];
      end

      // Hardware set beats a software clear in the same cycle
      always_ff @(posedge clk)
      begin
        if (srst)
          matchFlag_q[n] <= 1'b0;
        else if (modEvt[n])
          matchFlag_q[n] <= 1'b1;
        else if (wrCtrl)
          matchFlag_q[n] <= sfrWrData[n];
      end

      always_ff @(posedge clk)
      begin
        if (srst)
          toggle_q[n] <= 1'b1;
        else if (!effMode[n][CAWD_MM_TOG])
          toggle_q[n] <= 1'b1;
        else if (hit)
          toggle_q[n] <= !toggle_q[n];
      end

      always_ff @(posedge clk)
      begin
        if (srst)
          cexOut[n] <= 1'b0;
        else if (effMode[n][CAWD_MM_PWM] && effMode[n][CAWD_MM_PWM16])
          cexOut[n] <= effMode[n][CAWD_MM_ECOM] && (cnt_q >= {cmpHi_q[n], cmpLo_q[n]});
        else if (effMode[n][CAWD_MM_PWM] && !effMode[n][CAWD_MM_TOG])
          cexOut[n] <= effMode[n][CAWD_MM_ECOM] && (cnt_q[7:0] >= cmpLo_q[n]);
        else if (effMode[n][CAWD_MM_TOG])
          cexOut[n] <= toggle_q[n];
        else
          cexOut[n] <= 1'b0;
      end
    end
  endgenerate

  // Capture pins, read only past the second stage
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cexS1_q <= '0;
      cexS2_q <= '0;
      cexS3_q <= '0;
    end
    else
    begin
      cexS1_q <= cexIn;
      cexS2_q <= cexS1_q;
      cexS3_q <= cexS2_q;
    end
  end

  // ****************************************
  // Watchdog reset and interrupt
  // ****************************************
  assign wdMatch = (cmpHi_q[CAWD_WD_MODULE] == cnt_q[15:8]);

  always_ff @(posedge clk)
  begin
    if (srst)
      wdResetReq <= 1'b0;
    else
      wdResetReq <= wdOn && ((lowOvf && wdMatch)
        || (wrCtrl && sfrWrData[CAWD_CTRL_WDFLAG]));
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      irqReq <= 1'b0;
    else
      irqReq <= (ovfFlag_q && mode_q[CAWD_MODE_OVFIE]) || (|modIrq);
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
      sfrRdData <= 8'h00;
    else if (sfrRdEn)
    begin
      unique case (sfrAddr)
        CAWD_ADDR_CTRL: sfrRdData <= {ovfFlag_q, run_q, 3'h0, matchFlag_q};
        CAWD_ADDR_MODE: sfrRdData <= mode_q;
        CAWD_ADDR_MMODE0: sfrRdData <= effMode[0];
        CAWD_ADDR_MMODE1: sfrRdData <= effMode[1];
        CAWD_ADDR_MMODE2: sfrRdData <= effMode[2];
        CAWD_ADDR_CNTLO: sfrRdData <= cnt_q[7:0];
        CAWD_ADDR_CNTHI: sfrRdData <= cnt_q[15:8];
        CAWD_ADDR_CMPLO0: sfrRdData <= cmpLo_q[0];
        CAWD_ADDR_CMPLO1: sfrRdData <= cmpLo_q[1];
        CAWD_ADDR_CMPLO2: sfrRdData <= cmpLo_q[2];
        CAWD_ADDR_CMPHI0: sfrRdData <= cmpHi_q[0];
        CAWD_ADDR_CMPHI1: sfrRdData <= cmpHi_q[1];
        CAWD_ADDR_CMPHI2: sfrRdData <= cmpHi_q[2];
        default: sfrRdData <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_wd_timeout_reset:
    assert property (wdOn && lowOvf && wdMatch |=> wdResetReq)
    else $error("watchdog timeout did not raise reset");

  a_wd_forced_reset:
    assert property (wdOn && wrCtrl && sfrWrData[CAWD_CTRL_WDFLAG] |=> wdResetReq)
    else $error("flag write did not force reset");

  a_reset_has_cause:
    assert property (wdResetReq |-> $past(wdOn) && ($past(lowOvf) || $past(wrCtrl)))
    else $error("reset request without cause");

  a_counter_write_blocked:
    assert property (wdOn && (wrCntLo || wrCntHi) |=> cnt_q == 16'($past(cnt_q) + {15'h0, $past(countEn)}))
    else $error("counter written while watched");

  a_mode_frozen:
    assert property (wdOn && wrMode |=> mode_q[CAWD_MODE_TBMSB:CAWD_MODE_TBLSB]
      == $past(mode_q[CAWD_MODE_TBMSB:CAWD_MODE_TBLSB]) && mode_q[CAWD_MODE_IDLE] == $past(mode_q[CAWD_MODE_IDLE]))
    else $error("mode register changed while watched");

  a_lock_sticky:
    assert property (mode_q[CAWD_MODE_WATCHDOG_LOCK_BIT] |=> mode_q[CAWD_MODE_WATCHDOG_LOCK_BIT] && wdOn)
    else $error("lock released before reset");

  a_wd_reload_sum:
    assert property (wdOn && sfrWrEn && sfrAddr == CAWD_ADDR_CMPHI2 |=>
      cmpHi_q[2] == 8'($past(cnt_q[15:8]) + $past(cmpLo_q[2])))
    else $error("watchdog reload value wrong");

  a_forced_count:
    assert property (wdOn && countEn && !wrCntLo && !wrCntHi |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
    else $error("counter not advancing under watchdog");

  a_overflow_sticky:
    assert property (fullOvf |=> ovfFlag_q ##1 (ovfFlag_q || $past(wrCtrl)))
    else $error("overflow flag not sticky");

  a_reset_defaults:
    assert property ($fell(srst) |-> wdOn && cnt_q == CAWD_CNT_RST && cmpLo_q[2] == CAWD_CMP_RST
      && mode_q[CAWD_MODE_TBMSB:CAWD_MODE_TBLSB] == 3'h0)
    else $error("reset defaults wrong");

  a_mode_bit4_zero:
    assert property (!mode_q[CAWD_MODE_UNUSED])
    else $error("unused mode bit set");

  a_idle_halt:
    assert property (mode_q[CAWD_MODE_IDLE] && cpuIdle && !wrCntLo && !wrCntHi |=> cnt_q == $past(cnt_q))
    else $error("counter moved while suspended");

  c_wd_reset: cover property (wdOn && lowOvf && wdMatch);
  c_overflow: cover property (fullOvf);
  c_module_match: cover property (modEvt[0]);
  c_wd_disable: cover property (wdOn ##1 !wdOn);

endmodule : cawd_top

// ==== shared/cawd_pkg.sv ====
// Constants shared by the counter array watchdog block
package cawd_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] CAWD_ADDR_CTRL = 8'hd8;
  localparam logic [7:0] CAWD_ADDR_MODE = 8'hd9;
  localparam logic [7:0] CAWD_ADDR_MMODE0 = 8'hda;
  localparam logic [7:0] CAWD_ADDR_MMODE1 = 8'hdb;
  localparam logic [7:0] CAWD_ADDR_MMODE2 = 8'hdc;
  localparam logic [7:0] CAWD_ADDR_CNTLO = 8'hf9;
  localparam logic [7:0] CAWD_ADDR_CNTHI = 8'hfa;
  localparam logic [7:0] CAWD_ADDR_CMPLO0 = 8'hfb;
  localparam logic [7:0] CAWD_ADDR_CMPLO1 = 8'he9;
  localparam logic [7:0] CAWD_ADDR_CMPLO2 = 8'heb;
  localparam logic [7:0] CAWD_ADDR_CMPHI0 = 8'hfc;
  localparam logic [7:0] CAWD_ADDR_CMPHI1 = 8'hea;
  localparam logic [7:0] CAWD_ADDR_CMPHI2 = 8'hec;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CAWD_CTRL_OVF = 7;
  localparam int CAWD_CTRL_RUN = 6;
  localparam int CAWD_CTRL_WDFLAG = 2;
  localparam int CAWD_MODE_IDLE = 7;
  localparam int CAWD_MODE_WDEN = 6;
  localparam int CAWD_MODE_WATCHDOG_LOCK_BIT = 5;
  localparam int CAWD_MODE_UNUSED = 4;
  localparam int CAWD_MODE_TBMSB = 3;
  localparam int CAWD_MODE_TBLSB = 1;
  localparam int CAWD_MODE_OVFIE = 0;
  localparam int CAWD_MM_PWM16 = 7;
  localparam int CAWD_MM_ECOM = 6;
  localparam int CAWD_MM_CAPP = 5;
  localparam int CAWD_MM_CAPN = 4;
  localparam int CAWD_MM_MAT = 3;
  localparam int CAWD_MM_TOG = 2;
  localparam int CAWD_MM_PWM = 1;
  localparam int CAWD_MM_IRQEN = 0;
  localparam int CAWD_WD_MODULE = 2;

  // ****************************************
  // Reset values and fixed codes
  // ****************************************
  localparam logic [7:0] CAWD_MODE_RST = 8'h40;
  localparam logic [7:0] CAWD_MMODE_RST = 8'h00;
  localparam logic [7:0] CAWD_CMP_RST = 8'h00;
  localparam logic [15:0] CAWD_CNT_RST = 16'h0000;
  localparam logic [7:0] CAWD_MMODE_SWTIMER = 8'h48;
  localparam logic [15:0] CAWD_CNT_MAX = 16'hffff;
  localparam logic [7:0] CAWD_LOW_MAX = 8'hff;

  // ****************************************
  // Timebase
  // ****************************************
  localparam logic [3:0] CAWD_DIV12 = 4'hc;
  localparam logic [3:0] CAWD_DIV4 = 4'h4;
  localparam logic [3:0] CAWD_DIV8 = 4'h8;

  typedef enum logic [2:0] {
    CAWD_TB_SYS12 = 3'h0,
    CAWD_TB_SYS4 = 3'h1,
    CAWD_TB_TMR0 = 3'h2,
    CAWD_TB_ECI = 3'h3,
    CAWD_TB_SYS = 3'h4,
    CAWD_TB_EXT8 = 3'h5,
    CAWD_TB_RSV6 = 3'h6,
    CAWD_TB_RSV7 = 3'h7
  } cawd_tb_e;

endpackage : cawd_pkg

// ==== test/tb.sv ====
// Self-checking testbench for the counter array watchdog block
`timescale 1ns/1ps
module tb
  import cawd_pkg::*;
;
  // ****************************************
  // Signals and bookkeeping
  // ****************************************
  logic clk = 1'b0, srst = 1'b1, sfrWrEn = 1'b0, sfrRdEn = 1'b0, cpuIdle = 1'b0;
  logic timer0Ovf = 1'b0, eciPin = 1'b1, extClkPin = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00;
  logic [2:0] cexIn = 3'h0;
  logic [7:0] sfrRdData;
  logic [2:0] cexOut;
  logic irqReq, wdResetReq, wdPrev = 1'b0, wdLong = 1'b0;
  int error_cnt = 0, n_tests = 0, cyc = 0, wdHits = 0, seed = 63;
  logic [7:0] d, a, k, l, r;
  int n, e, h;

  cawd_top dut (.clk(clk), .srst(srst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
    .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .cpuIdle(cpuIdle), .timer0Ovf(timer0Ovf), .eciPin(eciPin),
    .extClkPin(extClkPin), .cexIn(cexIn), .cexOut(cexOut), .irqReq(irqReq), .wdResetReq(wdResetReq));

  initial forever #10 clk = ~clk;

  // Timebase sources: timer 0 every 4, count input falls every 8, external clock rises every 4
  always @(posedge clk)
  begin
    #1;
    cyc <= cyc + 1;
    timer0Ovf <= (cyc % 4 == 0);
    eciPin <= cyc[2];
    extClkPin <= cyc[1];
    cexIn <= $random(seed);
    if (cyc == 40000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // Pulse counter; a pulse longer than one cycle is never expected here
  always @(posedge clk)
  begin
    if (wdResetReq === 1'b1)
      wdHits <= wdHits + 1;
    if (wdResetReq === 1'b1 && wdPrev)
      wdLong <= 1'b1;
    wdPrev <= (wdResetReq === 1'b1);
  end

  // ****************************************
  // Tasks and expectation functions
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic doReset();
    srst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
  endtask : doReset

  // The idle cycle after each strobe keeps strobes from being reassigned in one step
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    sfrAddr = adr;
    sfrWrData = dat;
    sfrWrEn = 1'b1;
    @(posedge clk);
    #1;
    sfrWrEn = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] adr, output logic [7:0] dat);
    sfrAddr = adr;
    sfrRdEn = 1'b1;
    @(posedge clk);
    #1;
    sfrRdEn = 1'b0;
    dat = sfrRdData;
    @(posedge clk);
    #1;
  endtask : rd

  task automatic waitWd(input int maxc, output int cnt);
    cnt = 0;
    while (wdResetReq !== 1'b1 && cnt < maxc)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask : waitWd

  function automatic int wdTimeout(input logic [7:0] offs, input logic [7:0] low);
    return 256 * offs + 256 - low;
  endfunction : wdTimeout

  function automatic int expTicks(input int code, input int cycles);
    case (code)
      0: return cycles / 12;
      1, 2: return cycles / 4;
      3: return cycles / 8;
      4: return cycles;
      5: return cycles / 32;
      default: return 0;
    endcase
  endfunction : expTicks

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    doReset();
    rd(CAWD_ADDR_MODE, d); check("modeReset", d, 16'h0040);
    rd(CAWD_ADDR_CTRL, d); check("ctrlReset", d, 16'h0000);
    rd(CAWD_ADDR_CMPLO2, d); check("offsetReset", d, 16'h0000);
    rd(CAWD_ADDR_CNTHI, d); check("cntHiReset", d, 16'h0000);
    waitWd(4000, n);
    check("defaultTimeout", (n >= 3060 && n <= 3090), 1'b1);
    // Feed with offset and start count; first pass is the all-zero corner
    for (int i = 0; i < 3; i++)
    begin
      doReset();
      k = (i == 0) ? 8'h00 : ($random(seed) & 8'h03);
      l = (i == 0) ? 8'h00 : ($random(seed) & 8'h7f);
      wr(CAWD_ADDR_MODE, 8'h00);
      wr(CAWD_ADDR_MODE, 8'h08);
      wr(CAWD_ADDR_CMPLO2, k);
      wr(CAWD_ADDR_CNTLO, l);
      wr(CAWD_ADDR_CNTHI, 8'h00);
      wr(CAWD_ADDR_MODE, 8'h48);
      wr(CAWD_ADDR_CNTHI, 8'h80 | $random(seed));
      rd(CAWD_ADDR_CNTHI, d); check("cntHiLocked", d, 16'h0000);
      r = $random(seed);
      wr(CAWD_ADDR_MODE, 8'h40 | (r & 8'h9f));
      rd(CAWD_ADDR_MODE, d); check("modeFrozen", d, 16'h0048);
      wr(CAWD_ADDR_MMODE2, r);
      rd(CAWD_ADDR_MMODE2, d); check("mod2Forced", d, CAWD_MMODE_SWTIMER);
      rd(CAWD_ADDR_CTRL, d); check("runReadsZero", d & 8'h40, 16'h0000);
      rd(CAWD_ADDR_CNTLO, a);
      wr(CAWD_ADDR_CMPHI2, $random(seed));
      rd(CAWD_ADDR_CMPHI2, d); check("feedReload", d, k);
      e = wdTimeout(k, a) - 6;
      waitWd(2000, n);
      check("feedTimeout", (n >= e - 4 && n <= e + 4), 1'b1);
    end
    // Forced reset by flag write, and lock
    doReset();
    h = wdHits;
    wr(CAWD_ADDR_CTRL, 8'h04);
    @(posedge clk);
    #1;
    check("forcedReset", wdHits - h, 1);
    check("pulseWidth", wdLong, 1'b0);
    wr(CAWD_ADDR_MODE, 8'h20);
    wr(CAWD_ADDR_MODE, 8'h00);
    rd(CAWD_ADDR_MODE, d); check("lockHolds", d, 16'h0020);
    doReset();
    rd(CAWD_ADDR_MODE, d); check("lockCleared", d, 16'h0040);
    wr(CAWD_ADDR_MODE, 8'h00);
    wr(CAWD_ADDR_MODE, 8'h9f);
    rd(CAWD_ADDR_MODE, d); check("modeBit4", d, 16'h008f);
    // Timebase codes, counter released from the watchdog
    wr(CAWD_ADDR_CTRL, 8'h40);
    for (int c = 0; c < 8; c++)
    begin
      wr(CAWD_ADDR_MODE, 8'(c << 1));
      wr(CAWD_ADDR_CNTLO, 8'h00);
      repeat (96) @(posedge clk);
      #1;
      rd(CAWD_ADDR_CNTLO, d);
      check("timebase", (!$isunknown(d) && int'(d) >= expTicks(c, 97) - 2 && int'(d) <= expTicks(c, 97) + 2),
        1'b1);
    end
    // Overflow flag and its interrupt
    wr(CAWD_ADDR_MODE, 8'h09);
    wr(CAWD_ADDR_CNTLO, 8'hf0);
    wr(CAWD_ADDR_CNTHI, 8'hff);
    repeat (40) @(posedge clk);
    #1;
    rd(CAWD_ADDR_CTRL, d); check("ovfFlag", d & 8'hc0, 16'h00c0);
    check("ovfIrq", irqReq, 1'b1);
    wr(CAWD_ADDR_CTRL, 8'h40);
    check("ovfCleared", irqReq, 1'b0);
    // Module 0 software timer match
    wr(CAWD_ADDR_MMODE0, 8'h49);
    wr(CAWD_ADDR_CMPLO0, 8'h00);
    wr(CAWD_ADDR_CMPHI0, 8'h01);
    repeat (400) @(posedge clk);
    #1;
    rd(CAWD_ADDR_CTRL, d); check("matchFlag", d & 8'h07, 16'h0001);
    check("matchIrq", irqReq, 1'b1);
    wr(CAWD_ADDR_MMODE0, 8'h48);
    check("matchMasked", irqReq, 1'b0);
    rd(CAWD_ADDR_CTRL, d); check("flagSticky", d & 8'h07, 16'h0001);
    // Module 2 released: capture on either edge of its random pin
    wr(CAWD_ADDR_MMODE2, 8'h30);
    repeat (20) @(posedge clk);
    #1;
    rd(CAWD_ADDR_CTRL, d); check("captureFlag", d & 8'h04, 16'h0004);
    // Run bit and idle suspension
    wr(CAWD_ADDR_CTRL, 8'h00);
    rd(CAWD_ADDR_CNTLO, a);
    repeat (20) @(posedge clk);
    #1;
    rd(CAWD_ADDR_CNTLO, d); check("runStops", d, a);
    wr(CAWD_ADDR_MODE, 8'h88);
    wr(CAWD_ADDR_CTRL, 8'h40);
    cpuIdle = 1'b1;
    rd(CAWD_ADDR_CNTLO, a);
    repeat (20) @(posedge clk);
    #1;
    rd(CAWD_ADDR_CNTLO, d); check("idleHalts", d, a);
    cpuIdle = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    rd(CAWD_ADDR_CNTLO, d); check("idleResumes", d != a, 1'b1);
    // 16-bit PWM, full duty and compare disabled
    wr(CAWD_ADDR_MODE, 8'h08);
    wr(CAWD_ADDR_MMODE1, 8'h82);
    wr(CAWD_ADDR_CMPLO1, 8'h00);
    wr(CAWD_ADDR_CMPHI1, 8'h00);
    h = 0;
    repeat (300)
    begin
      @(posedge clk);
      #1;
      h += (cexOut[1] === 1'b1);
    end
    check("pwmFull", h, 300);
    wr(CAWD_ADDR_CMPLO1, 8'h00);
    h = 0;
    repeat (300)
    begin
      @(posedge clk);
      #1;
      h += (cexOut[1] !== 1'b0);
    end
    check("pwmOff", h, 0);
    rd(8'h00, d); check("unmapped", d, 16'h0000);
    conclude();
  end
endmodule : tb
